// >>> design/ext_edge_detect.sv
// Pin synchroniser and edge selector for one external interrupt pin
`timescale 1ns/10ps
`default_nettype none
module ext_edge_detect (
  input wire logic clk_sys_i,                     // System clock
  input wire logic rst_n_i,                       // Synchronised reset, active low
  input wire logic pin_i,                         // Asynchronous pin level
  input wire irq_bank_pkg::edge_mode_t mode_i,    // Edge selection
  output logic evt_o                              // One-cycle event pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

  always_comb begin
    case (mode_i)
      irq_bank_pkg::EDGE_OFF: evt_o = 1'b0; // RL14
      irq_bank_pkg::EDGE_RISE: evt_o = rise;
      irq_bank_pkg::EDGE_FALL: evt_o = fall;
      irq_bank_pkg::EDGE_BOTH: evt_o = rise | fall;
      default: evt_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> design/irq_enable_flag_bank.sv
// Interrupt request flag and enable register bank with vector request to the core
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "irq_bank_defs.svh"
// Overview of operation
// RL1: Global enable bit 0, resets to zero
// RL2: ADC flag bit6, enable bit3, bit7 zero
// RL3: Pin flags bits 5,4; enables 2,1
// RL4: Front-end ready flag bit7 resets one
// RL5: Group flags bits 6-4, enables 2-0
// RL6: Serial, uart, tick flags and enables
// RL7: Single uart: only SPI bits exist
// RL8: Dual uart adds second uart bits
// RL9: First timer group flags and enables
// RL10: Second timer group flags and enables
// RL11: Enable permits, flag shows pending request
// RL12: Flags set always; branch needs all three
// RL13: Taking a vector clears global enable
// RL14: Two-bit edge select per pin
// RL15: Newly set flag wakes from sleep
// RL16: Hardware set beats software clear
// RL17: Serviced flag auto-clears; group sub-flags stay
module irq_enable_flag_bank #(
  parameter bit DUAL_UART = 1'b1
) (
  input wire logic clk_sys_i,          // System clock, 40 MHz
  input wire logic rst_n_i,            // Asynchronous reset, active low
  input wire logic [3:0] addr_i,       // Register address
  input wire logic [7:0] wdata_i,      // Write data
  input wire logic wr_i,               // Write strobe
  input wire logic rd_i,               // Read strobe
  output logic [7:0] rdata_o,          // Read data, cycle after strobe
  input wire logic [1:0] ext_pin_i,    // External interrupt pins
  input wire logic adc_done_evt_i,     // Conversion done pulse
  input wire logic afe_ready_evt_i,    // Front-end ready pulse
  input wire logic group2_evt_i,       // Third group request pulse
  input wire logic serial_if_evt_i,    // Serial interface pulse
  input wire logic uart_a_evt_i,       // First uart pulse
  input wire logic uart_b_evt_i,       // Second uart pulse
  input wire logic tick0_evt_i,        // Time base 0 pulse
  input wire logic tick1_evt_i,        // Time base 1 pulse
  input wire logic spi_unit_evt_i,     // SPI pulse
  input wire logic [7:0] timer_evt_i,  // Timer compare match pulses
  input wire logic stack_full_i,       // Core stack full
  input wire logic irq_ack_i,          // Core takes the presented vector
  input wire logic sleep_i,            // Core in sleep or idle
  output logic irq_req_o,              // Vector request to core
  output logic [3:0] irq_vector_o,     // Requested vector number
  output logic wake_o                  // Wake-up pulse
);
  localparam irq_bank_pkg::vec_mask_t IMPL = DUAL_UART ? `MASK_DUAL : `MASK_SINGLE;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  irq_bank_pkg::vec_mask_t flag_reg;
  irq_bank_pkg::vec_mask_t en_reg;
  logic [7:0] sub_flag_reg;
  logic [7:0] sub_en_reg;
  logic gie_reg;
  logic [3:0] edge_sel_reg;
  logic [1:0] grp_cond_reg;
  logic irq_req_reg;
  irq_bank_pkg::vec_id_t irq_vector_reg;
  logic wake_reg;
  logic [7:0] rdata_reg;

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic [1:0] ext_evt;
  logic [1:0] grp_cond;
  irq_bank_pkg::vec_mask_t src_evt;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    ext_edge_detect u_edge (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_sync_n),
      .pin_i(ext_pin_i[p]),
      .mode_i(irq_bank_pkg::edge_mode_t'(edge_sel_reg[2*p +: 2])),
      .evt_o(ext_evt[p])
    );
  end

  // Group flags 0 and 1 set when the OR of their enabled sub-requests rises
  assign grp_cond[0] = |(sub_flag_reg[3:0] & sub_en_reg[3:0]);
  assign grp_cond[1] = |(sub_flag_reg[7:4] & sub_en_reg[7:4]);

  always_comb begin
    src_evt = '0;
    src_evt[`VEC_EXT0] = ext_evt[0];
    src_evt[`VEC_EXT1] = ext_evt[1];
    src_evt[`VEC_AFE] = afe_ready_evt_i;
    src_evt[`VEC_GRP0] = grp_cond[0] & ~grp_cond_reg[0];
    src_evt[`VEC_GRP1] = grp_cond[1] & ~grp_cond_reg[1];
    src_evt[`VEC_GRP2] = group2_evt_i;
    src_evt[`VEC_ADC] = adc_done_evt_i;
    src_evt[`VEC_SERIAL] = serial_if_evt_i;
    src_evt[`VEC_UART_A] = uart_a_evt_i;
    src_evt[`VEC_TICK0] = tick0_evt_i;
    src_evt[`VEC_TICK1] = tick1_evt_i;
    src_evt[`VEC_SPI] = spi_unit_evt_i;
    src_evt[`VEC_UART_B] = uart_b_evt_i & DUAL_UART; // RL8
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  irq_bank_pkg::vec_mask_t fl_we;
  irq_bank_pkg::vec_mask_t fl_wv;
  irq_bank_pkg::vec_mask_t en_we;
  irq_bank_pkg::vec_mask_t en_wv;

  always_comb begin
    fl_we = '0;
    fl_wv = '0;
    en_we = '0;
    en_wv = '0;
    if (wr_i) begin
      case (addr_i)
        `OFS_CTRL_A: begin
          {fl_we[`VEC_ADC], fl_we[`VEC_EXT1], fl_we[`VEC_EXT0]} = 3'h7; // RL2 RL3
          {fl_wv[`VEC_ADC], fl_wv[`VEC_EXT1], fl_wv[`VEC_EXT0]} = wdata_i[6:4];
          {en_we[`VEC_ADC], en_we[`VEC_EXT1], en_we[`VEC_EXT0]} = 3'h7;
          {en_wv[`VEC_ADC], en_wv[`VEC_EXT1], en_wv[`VEC_EXT0]} = wdata_i[3:1];
        end
        `OFS_CTRL_B: begin
          fl_we[`VEC_GRP2:`VEC_AFE] = 4'hF; // RL4 RL5
          fl_wv[`VEC_GRP2:`VEC_AFE] = {wdata_i[6:4], wdata_i[7]};
          en_we[`VEC_GRP2:`VEC_AFE] = 4'hF;
          en_wv[`VEC_GRP2:`VEC_AFE] = {wdata_i[2:0], wdata_i[3]};
        end
        `OFS_CTRL_C: begin
          fl_we[`VEC_TICK1:`VEC_SERIAL] = 4'hF; // RL6
          fl_wv[`VEC_TICK1:`VEC_SERIAL] = {wdata_i[5:4], wdata_i[6], wdata_i[7]};
          en_we[`VEC_TICK1:`VEC_SERIAL] = 4'hF;
          en_wv[`VEC_TICK1:`VEC_SERIAL] = {wdata_i[1:0], wdata_i[2], wdata_i[3]};
        end
        `OFS_CTRL_D: begin
          fl_we[`VEC_UART_B:`VEC_SPI] = {DUAL_UART, 1'b1}; // RL7 RL8
          fl_wv[`VEC_UART_B:`VEC_SPI] = wdata_i[5:4];
          en_we[`VEC_UART_B:`VEC_SPI] = {DUAL_UART, 1'b1};
          en_wv[`VEC_UART_B:`VEC_SPI] = wdata_i[1:0];
        end
        default: fl_we = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Flags and enables
  // ----------------------------------------
  irq_bank_pkg::vec_mask_t ack_clr;
  logic [7:0] sub_evt;

  assign ack_clr = irq_ack_i ? (13'h0001 << irq_vector_reg) : '0; // RL17
  assign sub_evt = timer_evt_i;

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_reg <= {5'h00, `RST_CTRL_B} >> 5; // RL3 RL4
    end else begin
      // Event set is ORed last so a same-cycle clear cannot lose it
      flag_reg <= ((((flag_reg & ~fl_we) | (fl_wv & fl_we)) & ~ack_clr)
                   | src_evt) & IMPL; // RL12 RL16 RL17
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      en_reg <= '0;
    end else begin
      en_reg <= ((en_reg & ~en_we) | (en_wv & en_we)) & IMPL; // RL11
    end
  end

  // Sub-flags are left for software after the group vector is taken
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sub_flag_reg <= '0;
      sub_en_reg <= '0;
    end else begin
      if (wr_i && addr_i == `OFS_GROUP_A) begin
        sub_flag_reg[3:0] <= wdata_i[7:4] | sub_evt[3:0]; // RL9 RL16
        sub_en_reg[3:0] <= wdata_i[3:0];
      end else begin
        sub_flag_reg[3:0] <= sub_flag_reg[3:0] | sub_evt[3:0];
      end
      if (wr_i && addr_i == `OFS_GROUP_B) begin
        sub_flag_reg[7:4] <= wdata_i[7:4] | sub_evt[7:4]; // RL10 RL16
        sub_en_reg[7:4] <= wdata_i[3:0];
      end else begin
        sub_flag_reg[7:4] <= sub_flag_reg[7:4] | sub_evt[7:4];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gie_reg <= 1'b0; // RL1
      edge_sel_reg <= `RST_EDGE_SEL;
      grp_cond_reg <= '0;
    end else begin
      if (irq_ack_i) begin
        gie_reg <= 1'b0; // RL13
      end else if (wr_i && addr_i == `OFS_CTRL_A) begin
        gie_reg <= wdata_i[0]; // RL1
      end
      if (wr_i && addr_i == `OFS_EDGE_SEL) begin
        edge_sel_reg <= wdata_i[3:0]; // RL14
      end
      grp_cond_reg <= grp_cond;
    end
  end

  // ----------------------------------------
  // Vector request and wake-up
  // ----------------------------------------
  logic found;
  irq_bank_pkg::vec_id_t win_idx;
  logic new_set;

  irq_vector_select u_sel (
    .pend_i(flag_reg & en_reg & IMPL),
    .found_o(found),
    .idx_o(win_idx)
  );

  assign new_set = |(src_evt & ~flag_reg & IMPL) | |(sub_evt & ~sub_flag_reg);

  // Request drops the cycle after the ack so the core never sees it twice
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_req_reg <= 1'b0;
      irq_vector_reg <= '0;
      wake_reg <= 1'b0;
    end else begin
      irq_req_reg <= found & gie_reg & ~stack_full_i & ~irq_ack_i; // RL12
      irq_vector_reg <= win_idx;
      wake_reg <= sleep_i & new_set; // RL15
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_CTRL_A: rdata_reg <= {1'b0, flag_reg[`VEC_ADC], flag_reg[`VEC_EXT1],
                                   flag_reg[`VEC_EXT0], en_reg[`VEC_ADC],
                                   en_reg[`VEC_EXT1], en_reg[`VEC_EXT0], gie_reg}; // RL2
        `OFS_CTRL_B: rdata_reg <= {flag_reg[`VEC_AFE], flag_reg[`VEC_GRP2:`VEC_GRP0],
                                   en_reg[`VEC_AFE], en_reg[`VEC_GRP2:`VEC_GRP0]}; // RL5
        `OFS_CTRL_C: rdata_reg <= {flag_reg[`VEC_SERIAL], flag_reg[`VEC_UART_A],
                                   flag_reg[`VEC_TICK1], flag_reg[`VEC_TICK0],
                                   en_reg[`VEC_SERIAL], en_reg[`VEC_UART_A],
                                   en_reg[`VEC_TICK1], en_reg[`VEC_TICK0]}; // RL6
        `OFS_CTRL_D: rdata_reg <= {2'h0, flag_reg[`VEC_UART_B], flag_reg[`VEC_SPI],
                                   2'h0, en_reg[`VEC_UART_B], en_reg[`VEC_SPI]}; // RL7 RL8
        `OFS_GROUP_A: rdata_reg <= {sub_flag_reg[3:0], sub_en_reg[3:0]}; // RL9
        `OFS_GROUP_B: rdata_reg <= {sub_flag_reg[7:4], sub_en_reg[7:4]}; // RL10
        `OFS_EDGE_SEL: rdata_reg <= {4'h0, edge_sel_reg};
        `OFS_STATUS: rdata_reg <= {found, 3'h0, win_idx};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_req_o = irq_req_reg;
  assign irq_vector_o = irq_vector_reg;
  assign wake_o = wake_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_sync_n);
  sequence ack_taken;
    irq_ack_i ##1 !gie_reg;
  endsequence
  sequence ack_quiet;
    !irq_req_o [*2];
  endsequence

  gie_block_a: assert property (!gie_reg |=> !irq_req_o) // RL1
    else $error("request raised while global enable is off");
  ack_nest_a: assert property (irq_ack_i && !wr_i |-> ack_taken ##0 ack_quiet) // RL13
    else $error("global enable or request survived vector take");
  en_gate_a: assert property (irq_req_o |-> $past(en_reg[win_idx])) // RL11
    else $error("request for a disabled source");
  evt_latch_a: assert property (adc_done_evt_i |=> flag_reg[`VEC_ADC]) // RL12
    else $error("conversion event not latched");
  set_wins_a: assert property (wr_i && addr_i == `OFS_CTRL_A && !wdata_i[6]
                               && adc_done_evt_i |=> flag_reg[`VEC_ADC]) // RL16
    else $error("clearing write lost a same-cycle event");
  ack_clear_a: assert property (irq_ack_i && irq_vector_o == `VEC_TICK0 && !tick0_evt_i
                                |=> !flag_reg[`VEC_TICK0]) // RL17
    else $error("serviced flag not cleared");
  sub_keep_a: assert property (irq_ack_i && !wr_i |=> // RL17
                               (sub_flag_reg & $past(sub_flag_reg)) == $past(sub_flag_reg))
    else $error("group sub-flags cleared by vector take");
  rd_ctrl_a_a: assert property (rd_i && addr_i == `OFS_CTRL_A |=>
                                !rdata_o[7] && rdata_o[0] == $past(gie_reg)) // RL2
    else $error("first control register read wrong");
  rd_ctrl_d_a: assert property (rd_i && addr_i == `OFS_CTRL_D |=> rdata_o[7:6] == 2'h0
                                && rdata_o[3:2] == 2'h0
                                && (DUAL_UART || (!rdata_o[5] && !rdata_o[1]))) // RL7 RL8
    else $error("unimplemented fourth register bits read nonzero");
  rd_ctrl_b_a: assert property (rd_i && addr_i == `OFS_CTRL_B |=>
                                rdata_o[7] == $past(flag_reg[`VEC_AFE])) // RL4
    else $error("front-end ready flag read wrong");
  edge_off_a: assert property (ext_evt[0] |-> edge_sel_reg[1:0] != 2'h0) // RL14
    else $error("pin event while edge select is off");
  wake_new_a: assert property (sleep_i && new_set |=> wake_o) // RL15
    else $error("newly set flag did not wake");
endmodule
`default_nettype wire

// >>> design/irq_vector_select.sv
// Fixed-priority selection of the pending vector, lowest number first
`timescale 1ns/10ps
`default_nettype none
module irq_vector_select (
  input wire irq_bank_pkg::vec_mask_t pend_i,   // Pending and enabled sources
  output logic found_o,                         // Some source is pending
  output irq_bank_pkg::vec_id_t idx_o           // Winning vector number
);
  always_comb begin
    found_o = 1'b0;
    idx_o = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (pend_i[i]) begin
        found_o = 1'b1;
        idx_o = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/core_ack_model.sv
// Behavioural core that takes a presented vector after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module core_ack_model (
  input wire logic clk_sys_i,      // System clock
  input wire logic rst_n_i,        // Reset, active low
  input wire logic irq_req_i,      // Vector request from the bank
  input wire logic ack_en_i,       // Core willing to take requests
  input wire logic [3:0] delay_i,  // Cycles of request before taking it
  output logic irq_ack_o           // One-cycle take pulse
);
  // ----------------------------------------
  // Take logic
  // ----------------------------------------
  logic [3:0] wait_reg;
  // The request falls one cycle after the take, so the pulse is dropped
  // unconditionally to avoid taking the same vector twice
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      irq_ack_o <= 1'b0;
    end else if (irq_ack_o) begin
      wait_reg <= 4'h0;
      irq_ack_o <= 1'b0;
    end else if (irq_req_i && ack_en_i) begin
      if (wait_reg == delay_i) begin
        irq_ack_o <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end else begin
      wait_reg <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/irq_enable_flag_bank_test.sv
// Self-checking testbench of the interrupt flag and enable bank
`timescale 1ns/10ps
`default_nettype none
module irq_enable_flag_bank_test;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] ext_pin_i = 2'h0;
  logic [12:0] fire = 13'h0000;
  logic [7:0] timer_evt_i = 8'h00;
  logic stack_full_i = 1'b0;
  logic sleep_i = 1'b0;
  logic ack_en = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic irq_ack_i;
  logic [7:0] rdata_o;
  logic [7:0] rdata_s;
  logic irq_req_o;
  logic [3:0] irq_vector_o;
  logic wake_o;
  int n_errors = 0;
  int num_checks = 0;
  int n_wake = 0;
  logic [7:0] rv;
  logic [12:0] pend;
  logic [7:0] d [7];
  logic [7:0] msk [7] = '{8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h0F};
  logic [3:0] vaddr [13] = '{0, 0, 1, 1, 1, 1, 0, 2, 2, 2, 2, 3, 3};
  logic [2:0] vbit [13] = '{4, 5, 7, 4, 5, 6, 6, 7, 6, 4, 5, 4, 5};

  irq_enable_flag_bank #(.DUAL_UART(1'b1)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_i(ext_pin_i),
    .adc_done_evt_i(fire[6]), .afe_ready_evt_i(fire[2]), .group2_evt_i(fire[5]),
    .serial_if_evt_i(fire[7]), .uart_a_evt_i(fire[8]), .uart_b_evt_i(fire[12]),
    .tick0_evt_i(fire[9]), .tick1_evt_i(fire[10]), .spi_unit_evt_i(fire[11]),
    .timer_evt_i(timer_evt_i), .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
    .sleep_i(sleep_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .wake_o(wake_o)
  );
  core_ack_model core_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o),
    .ack_en_i(ack_en), .delay_i(ack_dly), .irq_ack_o(irq_ack_i)
  );
  // Single-uart variant shares the bus; only its fourth register is compared
  irq_enable_flag_bank #(.DUAL_UART(1'b0)) dut_single_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_s), .ext_pin_i(ext_pin_i),
    .adc_done_evt_i(fire[6]), .afe_ready_evt_i(fire[2]), .group2_evt_i(fire[5]),
    .serial_if_evt_i(fire[7]), .uart_a_evt_i(fire[8]), .uart_b_evt_i(fire[12]),
    .tick0_evt_i(fire[9]), .tick1_evt_i(fire[10]), .spi_unit_evt_i(fire[11]),
    .timer_evt_i(timer_evt_i), .stack_full_i(stack_full_i), .irq_ack_i(1'b0),
    .sleep_i(sleep_i), .irq_req_o(), .irq_vector_o(), .wake_o()
  );

  // ----------------------------------------
  // Clock, wake counter, watchdog
  // ----------------------------------------
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (wake_o === 1'b1) n_wake++;
  end
  initial begin
    #500us;
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
  endtask
  task automatic pulse(input logic [12:0] f, input logic [7:0] t);
    @(posedge clk_sys_i);
    fire <= f;
    timer_evt_i <= t;
    @(posedge clk_sys_i);
    fire <= 13'h0000;
    timer_evt_i <= 8'h00;
  endtask
  // Sub-flag registers go first so no group flag rises afterwards
  task automatic clean_all();
    for (int k = 0; k < 7; k++) begin
      reg_wr(4'((k + 4) % 7), 8'h00);
    end
  endtask
  function automatic int lowest(input logic [12:0] m);
    lowest = 0;
    for (int k = 12; k >= 0; k--) begin
      if (m[k]) lowest = k;
    end
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int i;
    int m;
    int v;
    i = $urandom(32'h0208F980);
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (i = 0; i < 10; i++) begin
      reg_rd(4'(i));
      check(rv, (i == 1) ? 8'h80 : 8'h00);
    end
    for (m = 0; m < 3; m++) begin
      for (i = 0; i < 7; i++) begin
        d[(i + 4) % 7] = 8'($urandom);
        reg_wr(4'((i + 4) % 7), d[(i + 4) % 7]);
      end
      reg_wr(4'h9, 8'($urandom));
      reg_rd(4'h9);
      check(rv, 8'h00);
      for (i = 0; i < 7; i++) begin
        reg_rd(4'(i));
        check(rv, d[i] & msk[i]);
        if (i == 3) check(rdata_s, d[3] & 8'h11);
      end
    end
    clean_all();
    for (v = 2; v < 13; v++) begin
      if (v == 3 || v == 4) continue;
      pulse(13'h0001 << v, 8'h00);
      reg_rd(vaddr[v]);
      check(rv, 8'h01 << vbit[v]);
      check({7'h00, irq_req_o}, 8'h00);
      reg_wr(vaddr[v], 8'h00);
    end
    reg_wr(4'h4, 8'h0F);
    reg_wr(4'h5, 8'h0F);
    for (i = 0; i < 8; i++) begin
      pulse(13'h0000, 8'h01 << i);
      reg_rd(4'(4 + i / 4));
      check(rv, 8'h0F | (8'h10 << (i % 4)));
      reg_rd(4'h1);
      check(rv, 8'h10 << (i / 4));
      reg_wr(4'(4 + i / 4), 8'h0F);
      reg_wr(4'h1, 8'h00);
    end
    clean_all();
    ack_en <= 1'b1;
    for (m = 0; m < 4; m++) begin
      reg_wr(4'h1, 8'h0C);
      reg_wr(4'h2, 8'h0F);
      reg_wr(4'h3, 8'h03);
      reg_wr(4'h4, 8'hA0);
      reg_wr(4'h0, 8'h09);
      pend = 13'($urandom) & 13'h1FE4;
      if (pend == 13'h0000) pend = 13'h0040;
      ack_dly <= 4'($urandom_range(3, 0));
      stack_full_i <= 1'b1;
      pulse(pend, 8'h00);
      reg_rd(4'h7);
      check(rv, 8'h80 | 8'(lowest(pend)));
      repeat (4) @(posedge clk_sys_i);
      check({7'h00, irq_req_o}, 8'h00);
      stack_full_i <= 1'b0;
      while (pend != 13'h0000) begin
        v = lowest(pend);
        i = 0;
        while (irq_req_o !== 1'b1 && i < 40) begin
          @(posedge clk_sys_i);
          #1;
          i++;
        end
        check({4'h0, irq_vector_o}, 8'(v));
        i = 0;
        do begin
          @(posedge clk_sys_i);
          i++;
        end while (irq_ack_i !== 1'b1 && i < 40);
        #1;
        check({7'h00, irq_req_o}, 8'h00);
        reg_rd(vaddr[v]);
        check(rv & (8'h01 << vbit[v]), 8'h00);
        reg_rd(4'h0);
        check(rv & 8'h01, 8'h00);
        reg_wr(4'h0, rv | 8'h01);
        pend[v] = 1'b0;
      end
      reg_rd(4'h4);
      check(rv, 8'hA0);
    end
    ack_en <= 1'b0;
    clean_all();
    reg_wr(4'h0, 8'h40);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= 4'h0;
    wdata_i <= 8'h00;
    fire <= 13'h0040;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    fire <= 13'h0000;
    reg_rd(4'h0);
    check(rv, 8'h40);
    reg_wr(4'h0, 8'h00);
    for (m = 0; m < 4; m++) begin
      reg_wr(4'h6, 8'({m[1:0], m[1:0]}));
      for (i = 0; i < 2; i++) begin
        ext_pin_i <= (i == 0) ? 2'h3 : 2'h0;
        repeat (6) @(posedge clk_sys_i);
        reg_rd(4'h0);
        check(rv, m[i] ? 8'h30 : 8'h00);
        reg_wr(4'h0, 8'h00);
      end
    end
    sleep_i <= 1'b1;
    n_wake = 0;
    pulse(13'h0200, 8'h00);
    repeat (4) @(posedge clk_sys_i);
    check(8'(n_wake), 8'h01);
    pulse(13'h0200, 8'h00);
    repeat (4) @(posedge clk_sys_i);
    check(8'(n_wake), 8'h01);
    sleep_i <= 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> include/irq_bank_defs.svh
// Offsets, bit positions, reset values and vector numbers of the interrupt bank
`ifndef IRQ_BANK_DEFS_SVH
`define IRQ_BANK_DEFS_SVH
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_CTRL_C 4'h2
`define OFS_CTRL_D 4'h3
`define OFS_GROUP_A 4'h4
`define OFS_GROUP_B 4'h5
`define OFS_EDGE_SEL 4'h6
`define OFS_STATUS 4'h7
`define RST_CTRL_A 8'h00
`define RST_CTRL_B 8'h80
`define RST_EDGE_SEL 4'h0
`define NUM_VEC 13
`define VEC_EXT0 0
`define VEC_EXT1 1
`define VEC_AFE 2
`define VEC_GRP0 3
`define VEC_GRP1 4
`define VEC_GRP2 5
`define VEC_ADC 6
`define VEC_SERIAL 7
`define VEC_UART_A 8
`define VEC_TICK0 9
`define VEC_TICK1 10
`define VEC_SPI 11
`define VEC_UART_B 12
`define MASK_SINGLE 13'h0FFF
`define MASK_DUAL 13'h1FFF
`endif

// >>> include/irq_bank_pkg.sv
// Types shared by the interrupt bank modules
package irq_bank_pkg;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;
  typedef logic [3:0] vec_id_t;
  typedef logic [12:0] vec_mask_t;
endpackage
